// ===== core/vfd_pkg.sv
// vfd_pkg: shared constants and carrier types of the vliw fetch/dispatch unit
// assumes a single processor clock; no software-visible registers
package vfd_pkg;

  localparam int unsigned FETCH_W      = 256;
  localparam int unsigned INSN_W       = 32;
  localparam int unsigned SLOTS        = 8;
  localparam int unsigned SLOT_IDX_W   = 3;
  localparam int unsigned NUM_UNITS    = 8;
  localparam int unsigned RF_DEPTH     = 16;
  localparam int unsigned RF_IDX_W     = 4;
  localparam int unsigned LOAD_SIDE_W  = 64;
  localparam int unsigned ADDR_W       = 32;
  localparam int unsigned OFS_SHORT_W  = 5;
  localparam int unsigned OFS_LONG_W   = 15;

  // instruction field positions
  localparam int unsigned POS_CHAIN    = 0;
  localparam int unsigned POS_SIDE     = 1;
  localparam int unsigned POS_UNIT_LO  = 2;
  localparam int unsigned POS_OP_LO    = 4;
  localparam int unsigned POS_XPATH    = 7;
  localparam int unsigned POS_FLOAT    = 8;
  localparam int unsigned POS_SIZE_LO  = 9;
  localparam int unsigned POS_CIRC     = 11;
  localparam int unsigned POS_LONGOFS  = 12;
  localparam int unsigned POS_SRC2_LO  = 13;
  localparam int unsigned POS_SRC1_LO  = 18;
  localparam int unsigned POS_DST_LO   = 23;
  localparam int unsigned POS_ZCOND    = 28;
  localparam int unsigned POS_CREG_LO  = 29;

  // reset values and fixed constants
  localparam logic [ADDR_W-1:0]     RST_FETCH_ADDR = 32'h0000_0000;
  localparam logic [SLOT_IDX_W-1:0] RST_SLOT       = 3'h0;
  localparam logic [ADDR_W-1:0]     FETCH_STEP     = 32'h0000_0020;
  localparam logic [2:0]            CREG_ALWAYS    = 3'h0;

  typedef enum logic [1:0] {
    VFD_UNIT_LOGIC,
    VFD_UNIT_SHIFT,
    VFD_UNIT_MULT,
    VFD_UNIT_ADDR
  } vfd_unit_t;

  typedef enum logic [2:0] {
    VFD_OP_ARITH,
    VFD_OP_LOGIC,
    VFD_OP_BRANCH,
    VFD_OP_MUL,
    VFD_OP_LOAD,
    VFD_OP_STORE,
    VFD_OP_DWLOAD,
    VFD_OP_MOVE
  } vfd_op_t;

  typedef enum logic [1:0] {
    VFD_SZ_BYTE,
    VFD_SZ_HALF,
    VFD_SZ_WORD,
    VFD_SZ_DWORD
  } vfd_size_t;

  // one decoded unit slot
  typedef struct packed {
    logic                  valid;
    vfd_op_t               op;
    logic                  fp;
    logic                  xpath;
    logic                  dst_other;
    logic [2:0]            creg;
    logic                  zcond;
    logic [RF_IDX_W-1:0]   src1;
    logic [RF_IDX_W-1:0]   src2;
    logic [RF_IDX_W-1:0]   dst;
    vfd_size_t             size;
    logic                  circ;
    logic [OFS_LONG_W-1:0] ofs;
  } vfd_slot_t;

  // memory access request of one address unit
  typedef struct packed {
    logic                   valid;
    logic                   store;
    vfd_size_t              size;
    logic                   circ;
    logic [OFS_LONG_W-1:0]  ofs;
    logic [ADDR_W-1:0]      base;
    logic [LOAD_SIDE_W-1:0] wdata;
    logic                   dst_other;
    logic [RF_IDX_W-1:0]    reg_idx;
  } vfd_mem_t;

endpackage

// ===== core/vfd_regfile.sv
// vfd_regfile: one side's sixteen 32-bit general registers
// assumes writes from one side arrive at most once per cycle per port
`timescale 1ns/1ps
`default_nettype none
module vfd_regfile
  import vfd_pkg::*;
(
  // clock
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire logic                i_ce,
  // read ports: four local plus one cross
  input  wire logic [RF_IDX_W-1:0] i_raddr [5],
  output logic      [INSN_W-1:0]   o_rdata [5],
  // write ports: local and cross
  input  wire logic                i_we    [2],
  input  wire logic [RF_IDX_W-1:0] i_waddr [2],
  input  wire logic [INSN_W-1:0]   i_wdata [2]
);

  logic [INSN_W-1:0] mem_q [RF_DEPTH];

  // local port wins over a cross write to the same register
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      for (int i = 0; i < RF_DEPTH; i++)
        mem_q[i] <= '0;
    end
    else if (i_ce)
    begin
      if (i_we[1])
        mem_q[i_waddr[1]] <= i_wdata[1];
      if (i_we[0])
        mem_q[i_waddr[0]] <= i_wdata[0];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      for (int p = 0; p < 5; p++)
        o_rdata[p] <= '0;
    end
    else if (i_ce)
    begin
      for (int p = 0; p < 5; p++)
        o_rdata[p] <= mem_q[i_raddr[p]];
    end
  end

endmodule
`default_nettype wire

// ===== core/vfd_addr_gen.sv
// vfd_addr_gen: address unit effective address, linear or circular
// assumes the circular block size is a power of two given by i_circ_bits
`timescale 1ns/1ps
`default_nettype none
module vfd_addr_gen
  import vfd_pkg::*;
(
  // clock
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_ce,
  // request
  input  wire vfd_mem_t          i_req,
  input  wire logic [4:0]        i_circ_bits,
  // result
  output logic                   o_valid,
  output logic [ADDR_W-1:0]      o_addr,
  output vfd_mem_t               o_req
);

  function automatic logic [ADDR_W-1:0] scale_ofs(input logic [OFS_LONG_W-1:0] ofs,
                                                  input vfd_size_t sz);
    logic [ADDR_W-1:0] ext;
    ext = {{(ADDR_W-OFS_LONG_W){1'b0}}, ofs};
    scale_ofs = ext << sz;
  endfunction

  logic [ADDR_W-1:0] lin;
  logic [ADDR_W-1:0] mask;

  always_comb
  begin
    lin  = i_req.base + scale_ofs(i_req.ofs, i_req.size);
    mask = (32'h0000_0001 << i_circ_bits) - 32'h0000_0001;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_valid <= 1'b0;
      o_addr  <= '0;
      o_req   <= '0;
    end
    else if (i_ce)
    begin
      o_valid <= i_req.valid;
      o_req   <= i_req;
      // circular mode keeps the upper bits of the base
      o_addr  <= i_req.circ ? ((i_req.base & ~mask) | (lin & mask)) : lin;
    end
  end

endmodule
`default_nettype wire

// ===== core/vfd_core.sv
// vfd_core: fetch and dispatch front end of an eight-issue vliw core
// assumes a program memory that answers a fetch request with one whole packet
`timescale 1ns/1ps
`default_nettype none
module vfd_core
  import vfd_pkg::*;
(
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_ce,
  // program memory
  output logic                        o_fetch_req,
  output logic [ADDR_W-1:0]           o_fetch_addr,
  input  wire logic                   i_fetch_valid,
  input  wire logic [FETCH_W-1:0]     i_fetch_data,
  // branch redirect from execute
  input  wire logic                   i_branch,
  input  wire logic [ADDR_W-1:0]      i_branch_addr,
  // issue to the eight units, a side first
  output vfd_slot_t                   o_unit [NUM_UNITS],
  output logic                        o_group_valid,
  output logic [SLOT_IDX_W:0]         o_group_size,
  // memory side of the two address units
  input  wire logic [4:0]             i_circ_bits,
  output logic                        o_mem_valid [2],
  output logic [ADDR_W-1:0]           o_mem_addr  [2],
  output vfd_mem_t                    o_mem_req   [2],
  input  wire logic                   i_load_valid [2],
  input  wire logic [LOAD_SIDE_W-1:0] i_load_data  [2],
  // write back from execute, one per side
  input  wire logic                   i_wb_valid [2],
  input  wire logic                   i_wb_other [2],
  input  wire logic [RF_IDX_W-1:0]    i_wb_idx   [2],
  input  wire logic [INSN_W-1:0]      i_wb_data  [2],
  // register operands, four local plus cross per side
  output logic [INSN_W-1:0]           o_opnd [2][5]
);

  // ---------------------------------------------------------------
  // fetch
  // ---------------------------------------------------------------
  typedef enum logic [1:0] { VFD_FETCH, VFD_WAIT, VFD_ISSUE } vfd_state_t;

  vfd_state_t             state_q;
  logic [FETCH_W-1:0]     pkt_q;
  logic [SLOT_IDX_W-1:0]  slot_q;
  logic [ADDR_W-1:0]      addr_q;

  function automatic logic [INSN_W-1:0] slot_word(input logic [FETCH_W-1:0] pkt,
                                                  input int unsigned idx);
    slot_word = pkt[idx*INSN_W +: INSN_W];
  endfunction

  // group length from the current slot: count while chain bits stay set
  logic [SLOT_IDX_W:0] grp_len;
  logic                grp_last;

  always_comb
  begin
    logic stop;
    logic [INSN_W-1:0] wk;
    grp_len = '0;
    stop    = 1'b0;
    wk      = '0;
    for (int unsigned k = 0; k < SLOTS; k++)
    begin
      if (k >= slot_q && !stop)
      begin
        grp_len = grp_len + 1'b1;
        wk      = slot_word(pkt_q, k);
        if (!wk[POS_CHAIN])
          stop = 1'b1;
      end
    end
    // packet end also closes a group left open
    grp_last = ({1'b0, slot_q} + grp_len) >= (SLOT_IDX_W+1)'(SLOTS);
  end

  // next request waits for last group or a branch redirect
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_q <= VFD_FETCH;
      slot_q  <= RST_SLOT;
      addr_q  <= RST_FETCH_ADDR;
      pkt_q   <= '0;
    end
    else if (i_ce)
    begin
      case (state_q)
        VFD_FETCH:
          state_q <= VFD_WAIT;
        VFD_WAIT:
          if (i_fetch_valid)
          begin
            pkt_q   <= i_fetch_data;
            slot_q  <= RST_SLOT;
            state_q <= VFD_ISSUE;
          end
        VFD_ISSUE:
          if (i_branch)
          begin
            addr_q  <= i_branch_addr;
            state_q <= VFD_FETCH;
          end
          else if (grp_last)
          begin
            addr_q  <= addr_q + FETCH_STEP;
            state_q <= VFD_FETCH;
          end
          else
            slot_q <= SLOT_IDX_W'(slot_q + grp_len);
        default:
          state_q <= VFD_FETCH;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_fetch_req  <= 1'b0;
      o_fetch_addr <= RST_FETCH_ADDR;
    end
    else if (i_ce)
    begin
      o_fetch_req  <= (state_q == VFD_FETCH);
      o_fetch_addr <= addr_q;
    end
  end

  // ---------------------------------------------------------------
  // decode and unit steering
  // ---------------------------------------------------------------
  function automatic vfd_slot_t decode(input logic [INSN_W-1:0] w);
    vfd_slot_t s;
    s.valid     = 1'b1;
    s.op        = vfd_op_t'(w[POS_OP_LO +: 3]);
    s.fp        = w[POS_FLOAT];
    s.xpath     = w[POS_XPATH];
    s.dst_other = w[POS_XPATH];
    // condition fields travel with the unit
    s.creg      = w[POS_CREG_LO +: 3];
    s.zcond     = w[POS_ZCOND];
    s.src1      = w[POS_SRC1_LO +: RF_IDX_W];
    s.src2      = w[POS_SRC2_LO +: RF_IDX_W];
    s.dst       = w[POS_DST_LO +: RF_IDX_W];
    s.size      = vfd_size_t'(w[POS_SIZE_LO +: 2]);
    s.circ      = w[POS_CIRC];
    s.ofs       = w[POS_LONGOFS] ? w[POS_SRC2_LO +: OFS_LONG_W]
                                 : {{(OFS_LONG_W-OFS_SHORT_W){1'b0}},
                                    w[POS_SRC2_LO +: OFS_SHORT_W]};
    decode = s;
  endfunction

  // unit index: side*4 + unit kind
  function automatic logic [SLOT_IDX_W-1:0] unit_of(input logic [INSN_W-1:0] w);
    unit_of = {w[POS_SIDE], w[POS_UNIT_LO +: 2]};
  endfunction

  // per-unit legality of an op
  function automatic logic op_ok(input vfd_unit_t u, input vfd_slot_t s);
    case (u)
      VFD_UNIT_MULT:  op_ok = (s.op == VFD_OP_MUL);
      VFD_UNIT_SHIFT: op_ok = !s.fp && (s.op inside {VFD_OP_ARITH, VFD_OP_LOGIC,
                                       VFD_OP_BRANCH, VFD_OP_MOVE, VFD_OP_DWLOAD});
      VFD_UNIT_LOGIC: op_ok = s.op inside {VFD_OP_ARITH, VFD_OP_LOGIC, VFD_OP_MOVE};
      VFD_UNIT_ADDR:  op_ok = s.op inside {VFD_OP_LOAD, VFD_OP_STORE,
                                           VFD_OP_ARITH, VFD_OP_MOVE};
      default:        op_ok = 1'b0;
    endcase
  endfunction

  vfd_slot_t unit_d [NUM_UNITS];
  logic      xread_used [2];

  always_comb
  begin
    logic [INSN_W-1:0] w;
    logic [SLOT_IDX_W-1:0] u;
    vfd_slot_t s;
    w = '0;
    u = '0;
    s = '0;
    for (int i = 0; i < NUM_UNITS; i++)
      unit_d[i] = '0;
    xread_used[0] = 1'b0;
    xread_used[1] = 1'b0;
    for (int unsigned k = 0; k < SLOTS; k++)
    begin
      if (k >= slot_q && k < slot_q + grp_len)
      begin
        w = slot_word(pkt_q, k);
        u = unit_of(w);
        s = decode(w);
        // float accepted on all but shift units
        // second cross read on a side is dropped
        if (op_ok(vfd_unit_t'(u[1:0]), s) && !unit_d[u].valid
            && !(s.xpath && xread_used[u[2]]))
        begin
          unit_d[u] = s;
          if (s.xpath)
            xread_used[u[2]] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_group_valid <= 1'b0;
      o_group_size  <= '0;
      for (int i = 0; i < NUM_UNITS; i++)
        o_unit[i] <= '0;
    end
    else if (i_ce)
    begin
      o_group_valid <= (state_q == VFD_ISSUE);
      o_group_size  <= (state_q == VFD_ISSUE) ? grp_len : '0;
      for (int i = 0; i < NUM_UNITS; i++)
        o_unit[i] <= (state_q == VFD_ISSUE) ? unit_d[i] : '0;
    end
  end

  // ---------------------------------------------------------------
  // register files and cross paths
  // ---------------------------------------------------------------
  logic [RF_IDX_W-1:0] raddr [2][5];
  logic [INSN_W-1:0]   rdata [2][5];
  logic                rf_we [2][2];
  logic [RF_IDX_W-1:0] rf_wa [2][2];
  logic [INSN_W-1:0]   rf_wd [2][2];

  always_comb
  begin
    for (int sd = 0; sd < 2; sd++)
    begin
      for (int k = 0; k < 4; k++)
        raddr[sd][k] = unit_d[sd*4+k].src1;
      raddr[sd][4] = '0;
    end
    // cross bus reads the other side
    for (int sd = 0; sd < 2; sd++)
      for (int k = 0; k < 4; k++)
        if (unit_d[(1-sd)*4+k].valid && unit_d[(1-sd)*4+k].xpath)
          raddr[sd][4] = unit_d[(1-sd)*4+k].src2;
    for (int sd = 0; sd < 2; sd++)
    begin
      rf_we[sd][0] = i_wb_valid[sd] && !i_wb_other[sd];
      rf_wa[sd][0] = i_wb_idx[sd];
      rf_wd[sd][0] = i_wb_data[sd];
      rf_we[sd][1] = i_wb_valid[1-sd] && i_wb_other[1-sd];
      rf_wa[sd][1] = i_wb_idx[1-sd];
      rf_wd[sd][1] = i_wb_data[1-sd];
    end
  end

  vfd_regfile u_rf_a (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_ce    (i_ce),
    .i_raddr (raddr[0]),
    .o_rdata (rdata[0]),
    .i_we    (rf_we[0]),
    .i_waddr (rf_wa[0]),
    .i_wdata (rf_wd[0])
  );

  vfd_regfile u_rf_b (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_ce    (i_ce),
    .i_raddr (raddr[1]),
    .o_rdata (rdata[1]),
    .i_we    (rf_we[1]),
    .i_waddr (rf_wa[1]),
    .i_wdata (rf_wd[1])
  );

  always_comb
  begin
    for (int sd = 0; sd < 2; sd++)
    begin
      for (int k = 0; k < 4; k++)
        o_opnd[sd][k] = rdata[sd][k];
      // cross operand comes from the opposite file
      o_opnd[sd][4] = rdata[1-sd][4];
    end
  end

  // ---------------------------------------------------------------
  // address units
  // ---------------------------------------------------------------
  vfd_mem_t mreq [2];

  always_comb
  begin
    vfd_slot_t s;
    s = '0;
    for (int sd = 0; sd < 2; sd++)
    begin
      s = unit_d[sd*4+int'(VFD_UNIT_ADDR)];
      mreq[sd] = '0;
      // only in an issue cycle, else a stale slot would repeat its access
      mreq[sd].valid     = s.valid && (state_q == VFD_ISSUE)
                           && (s.op inside {VFD_OP_LOAD, VFD_OP_STORE});
      mreq[sd].store     = (s.op == VFD_OP_STORE);
      mreq[sd].size      = (s.size == VFD_SZ_DWORD) ? VFD_SZ_WORD : s.size;
      mreq[sd].circ      = s.circ;
      mreq[sd].ofs       = s.ofs;
      mreq[sd].base      = {{(ADDR_W-RF_IDX_W){1'b0}}, s.src1};
      mreq[sd].dst_other = s.dst_other;
      mreq[sd].reg_idx   = s.dst;
      mreq[sd].wdata     = {32'h0000_0000, i_wb_data[sd]};
    end
  end

  vfd_addr_gen u_ag_a (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_ce        (i_ce),
    .i_req       (mreq[0]),
    .i_circ_bits (i_circ_bits),
    .o_valid     (o_mem_valid[0]),
    .o_addr      (o_mem_addr[0]),
    .o_req       (o_mem_req[0])
  );

  vfd_addr_gen u_ag_b (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_ce        (i_ce),
    .i_req       (mreq[1]),
    .i_circ_bits (i_circ_bits),
    .o_valid     (o_mem_valid[1]),
    .o_addr      (o_mem_addr[1]),
    .o_req       (o_mem_req[1])
  );

endmodule
`default_nettype wire

// ===== testbench/vfd_core_monitor.sv
// vfd_core_monitor: concurrent checks on the fetch and dispatch ports of vfd_core
// assumes one clock and the synchronous active-high reset of the core
`timescale 1ns/1ps
`default_nettype none
module vfd_core_monitor
  import vfd_pkg::*;
(
  // clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  // program memory side
  input  wire logic                o_fetch_req,
  input  wire logic [ADDR_W-1:0]   o_fetch_addr,
  input  wire logic                i_fetch_valid,
  // issue side
  input  wire vfd_slot_t           o_unit [NUM_UNITS],
  input  wire logic                o_group_valid,
  input  wire logic [SLOT_IDX_W:0] o_group_size
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic                 wait_q;
  logic                 seen_q;
  logic [ADDR_W-1:0]    last_q;
  logic [4:0]           sum_q;
  logic [NUM_UNITS-1:0] uv;

  for (genvar k = 0; k < NUM_UNITS; k++)
  begin : g_uv
    assign uv[k] = o_unit[k].valid;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst) wait_q <= 1'b0;
    else if (o_fetch_req) wait_q <= 1'b1;
    else if (i_fetch_valid) wait_q <= 1'b0;
  end

  // slots handed out since the packet arrived; padding counts as slots
  always_ff @(posedge i_clk)
  begin
    if (i_rst || (i_fetch_valid && wait_q)) sum_q <= '0;
    else if (o_group_valid) sum_q <= sum_q + 5'(o_group_size);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst) seen_q <= 1'b0;
    else if (o_fetch_req) seen_q <= 1'b1;
    if (o_fetch_req) last_q <= o_fetch_addr;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_req_pulse: assert property (o_fetch_req |=> !o_fetch_req)
    else $error("fetch request held over one cycle");
  a_req_quiet: assert property (o_group_valid |-> !o_fetch_req)
    else $error("fetch request while a group issues");
  a_fetch_after: assert property ($fell(o_group_valid) |-> ##[0:2] o_fetch_req)
    else $error("no fetch request after last group");
  a_answer_time: assert property (wait_q && i_fetch_valid |-> ##2 o_group_valid)
    else $error("first group not two cycles after packet");
  a_stall_wait: assert property (wait_q |-> !o_group_valid)
    else $error("group issued before packet arrived");
  a_group_size: assert property (o_group_valid |-> o_group_size inside {[1:8]})
    else $error("group size out of range");
  a_idle_units: assert property (!o_group_valid |-> uv == '0)
    else $error("unit active without a group");
  a_units_fit: assert property (o_group_valid |-> $countones(uv) <= o_group_size)
    else $error("more active units than group slots");
  a_back_to_back: assert property (o_group_valid && (sum_q + o_group_size < 5'd8)
    |=> o_group_valid)
    else $error("gap between groups of one packet");
  a_packet_sum: assert property (o_fetch_req && seen_q |-> sum_q == 5'd8)
    else $error("packet not eight slots when refetching");
  a_addr_step: assert property (o_fetch_req && seen_q
    |-> o_fetch_addr == last_q + FETCH_STEP)
    else $error("fetch address not one packet on");
  a_first_fetch: assert property ($fell(i_rst)
    |-> ##[0:2] (o_fetch_req && o_fetch_addr == RST_FETCH_ADDR))
    else $error("no first fetch after reset");
endmodule

bind vfd_core vfd_core_monitor u_mon (
  .i_clk(i_clk),
  .i_rst(i_rst),
  .o_fetch_req(o_fetch_req),
  .o_fetch_addr(o_fetch_addr),
  .i_fetch_valid(i_fetch_valid),
  .o_unit(o_unit),
  .o_group_valid(o_group_valid),
  .o_group_size(o_group_size)
);
`default_nettype wire

// ===== testbench/vfd_prog_mem.sv
// vfd_prog_mem: program memory model answering each fetch with one packet
// assumes the bench supplies packet content and answer latency
`timescale 1ns/1ps
`default_nettype none
module vfd_prog_mem
  import vfd_pkg::*;
(
  // clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  // request from the core, packet content and latency from the bench
  input  wire logic               i_fetch_req,
  input  wire logic [FETCH_W-1:0] i_pkt,
  input  wire logic [7:0]         i_lat,
  // answer
  output logic                    o_fetch_valid,
  output logic [FETCH_W-1:0]      o_fetch_data
);
  logic       busy_q;
  logic [7:0] cnt_q;

  always_ff @(posedge i_clk)
  begin
    o_fetch_valid <= 1'b0;
    // data toggles when not answering so a stale packet is never reused
    o_fetch_data  <= ~o_fetch_data;
    if (i_rst)
    begin
      busy_q       <= 1'b0;
      o_fetch_data <= '1;
    end
    else if (i_fetch_req)
    begin
      busy_q <= 1'b1;
      cnt_q  <= i_lat;
    end
    else if (busy_q && cnt_q <= 8'h01)
    begin
      busy_q        <= 1'b0;
      o_fetch_valid <= 1'b1;
      o_fetch_data  <= i_pkt;
    end
    else if (busy_q)
      cnt_q <= cnt_q - 8'h01;
  end
endmodule
`default_nettype wire

// ===== testbench/test_vliw_fetch_dispatch_unit.sv
// test_vliw_fetch_dispatch_unit: directed bench for the fetch and dispatch core
// assumes vfd_prog_mem as program memory and the bound port monitor
`timescale 1ns/1ps
`default_nettype none
module test_vliw_fetch_dispatch_unit
  import vfd_pkg::*;
;
  logic                   clk;
  logic                   rst;
  logic                   ce;
  logic                   fetch_req;
  logic [ADDR_W-1:0]      fetch_addr;
  logic                   fetch_valid;
  logic [FETCH_W-1:0]     fetch_data;
  logic                   branch;
  logic [ADDR_W-1:0]      branch_addr;
  logic [4:0]             circ_bits;
  vfd_slot_t              unit [NUM_UNITS];
  logic                   group_valid;
  logic [SLOT_IDX_W:0]    group_size;
  logic                   load_valid [2];
  logic [LOAD_SIDE_W-1:0] load_data [2];
  logic                   wb_valid [2];
  logic                   wb_other [2];
  logic [RF_IDX_W-1:0]    wb_idx [2];
  logic [INSN_W-1:0]      wb_data [2];
  logic                   mem_valid [2];
  logic [INSN_W-1:0]      opnd [2][5];
  logic [INSN_W-1:0]      exp_ra;
  logic [INSN_W-1:0]      exp_rb;
  logic [FETCH_W-1:0]     pkt;
  logic [7:0]             lat;
  logic [ADDR_W-1:0]      exp_addr;
  int                     fail_count;
  int                     n_compared;

  always #2 clk = ~clk;

  vfd_core dut (
    .i_clk(clk), .i_rst(rst), .i_ce(ce),
    .o_fetch_req(fetch_req), .o_fetch_addr(fetch_addr),
    .i_fetch_valid(fetch_valid), .i_fetch_data(fetch_data),
    .i_branch(branch), .i_branch_addr(branch_addr),
    .o_unit(unit), .o_group_valid(group_valid), .o_group_size(group_size),
    .i_circ_bits(circ_bits), .o_mem_valid(mem_valid), .o_mem_addr(), .o_mem_req(),
    .i_load_valid(load_valid), .i_load_data(load_data),
    .i_wb_valid(wb_valid), .i_wb_other(wb_other), .i_wb_idx(wb_idx),
    .i_wb_data(wb_data), .o_opnd(opnd)
  );

  vfd_prog_mem u_mem (
    .i_clk(clk), .i_rst(rst), .i_fetch_req(fetch_req), .i_pkt(pkt),
    .i_lat(lat), .o_fetch_valid(fetch_valid), .o_fetch_data(fetch_data)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cmp_bits(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // unit index is side*4+kind; each kind gets an op it accepts
  function automatic logic [INSN_W-1:0] insn(input logic [2:0] u, input logic chain);
    insn = '0;
    insn[POS_CHAIN] = chain;
    insn[POS_SIDE] = u[2];
    insn[POS_UNIT_LO +: 2] = u[1:0];
    insn[POS_OP_LO +: 3] = (u[1:0] == 2'h2) ? VFD_OP_MUL
                         : (u[1:0] == 2'h3) ? VFD_OP_LOAD : VFD_OP_ARITH;
  endfunction

  function automatic logic [7:0] uvec();
    for (int k = 0; k < 8; k++)
      uvec[k] = unit[k].valid;
  endfunction

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // slot k targets unit units[3k+:3]; expected groups follow the chain bits
  task automatic run_pkt(input logic [23:0] units, input logic [7:0] chain, input logic [7:0] l);
    int unsigned n;
    int unsigned s;
    logic [7:0]  mask;
    for (int k = 0; k < 8; k++)
      pkt[k*INSN_W +: INSN_W] = insn(units[k*3 +: 3], chain[k]);
    lat = l;
    n = 0;
    while (fetch_req !== 1'b1 && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    cmp_bits(fetch_addr, exp_addr, "fetch address");
    exp_addr = exp_addr + FETCH_STEP;
    n = 0;
    while (group_valid !== 1'b1 && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    cmp_bits(n, l + 3, "dispatch latency");
    s = 0;
    mask = '0;
    for (int k = 0; k < 8; k++)
    begin
      mask[units[k*3 +: 3]] = 1'b1;
      s++;
      if (!chain[k] || k == 7)
      begin
        cmp_bits(group_valid, 1, "group valid");
        cmp_bits(group_size, s, "group size");
        cmp_bits(uvec(), mask, "unit valids");
        cmp_bits(opnd[0][0], exp_ra, "side a operand");
        cmp_bits(opnd[1][0], exp_rb, "side b operand");
        cmp_bits(opnd[0][4], exp_rb, "cross operand a");
        cmp_bits(opnd[1][4], exp_ra, "cross operand b");
        cmp_bits({mem_valid[1], mem_valid[0]}, {mask[7], mask[3]}, "memory request");
        @(negedge clk);
        s = 0;
        mask = '0;
      end
    end
    cmp_bits(group_valid, 0, "extra group");
    cmp_bits({mem_valid[1], mem_valid[0]}, 0, "memory request idle");
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_full_group;
    run_pkt(24'hfac688, 8'h7f, 8'h01);
  endtask

  task automatic t_single_groups;
    run_pkt(24'hfac688, 8'h00, 8'h01);
  endtask

  task automatic t_mixed_slow;
    run_pkt(24'hc8fac4, 8'h73, 8'h06);
  endtask

  task automatic t_seven_one;
    run_pkt(24'h053977, 8'h3f, 8'h02);
  endtask

  // writebacks land while the packet is awaited; local beats cross on one register
  task automatic t_write_back;
    exp_ra = 32'h1111_2222;
    exp_rb = 32'h5555_6666;
    fork
      run_pkt(24'hfac688, 8'h0f, 8'h03);
      begin
        wb_valid = '{1'b1, 1'b1};
        wb_other = '{1'b0, 1'b1};
        wb_data = '{32'h1111_2222, 32'h3333_4444};
        @(negedge clk);
        wb_valid[1] = 1'b0;
        wb_other[0] = 1'b1;
        wb_data[0] = 32'h5555_6666;
        @(negedge clk);
        wb_valid[0] = 1'b0;
      end
    join
  endtask

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    branch = 1'b0;
    branch_addr = '0;
    circ_bits = 5'h04;
    load_valid = '{default: 1'b0};
    load_data = '{default: '0};
    wb_valid = '{default: 1'b0};
    wb_other = '{default: 1'b0};
    wb_idx = '{default: '0};
    wb_data = '{default: '0};
    pkt = '0;
    lat = 8'h01;
    exp_addr = RST_FETCH_ADDR;
    exp_ra = '0;
    exp_rb = '0;
    fail_count = 0;
    n_compared = 0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    t_full_group();
    t_single_groups();
    t_mixed_slow();
    t_seven_one();
    t_write_back();
    end_of_test();
  end

  // a full run needs well under 200 cycles
  initial
  begin
    repeat (2000) @(posedge clk);
    fail_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_of_test();
  end
endmodule
`default_nettype wire
